// file: shared/alu_consts.svh
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

// register byte offsets on the bus
`define REG_SRCA 8'h00
`define REG_SRCB 8'h04
`define REG_SRCC 8'h08
`define REG_CMD 8'h0C
`define REG_RESLO 8'h10
`define REG_RESHI 8'h14
`define REG_STATUS 8'h18
`define REG_ARITH 8'h1C

// status bits
`define ST_BUSY 0
`define ST_OVF_FAULT 1
`define ST_ZDIV_FAULT 2

// arithmetic controls fields
`define CTL_CC_MSB 2
`define CTL_OVF_FLAG 8
`define CTL_OVF_MASK 12
`define CC_CARRY 1
`define CC_OVF 0
`define CC_TRUE 3'h2
`define CC_FALSE 3'h0
`define CC_RESET 3'h0

// widths and counts
`define OP_MSB 5
`define WORD_BITS 32'h20
`define MAX_SHIFT 31
`define ALL_ONES 32'hFFFFFFFF
`define ZERO_WORD 32'h00000000
`define INT_MIN 32'h80000000
`define DIV_STEPS 7'h40
`define DIV_LAST 7'h01

`endif

// file: shared/alu_pkg.sv
`default_nettype none
package alu_pkg;

  // command codes, numbered 0 upward in this order
  typedef enum logic [5:0] {
    OP_ADDI, OP_ADDO, OP_SUBI, OP_SUBO, OP_MULI, OP_MULO, OP_DIVI, OP_DIVO,
    OP_REMI, OP_REMO, OP_MODI, OP_SHLO, OP_SHRO, OP_SHLI, OP_SHRI, OP_SHRDI,
    OP_ROTATE, OP_ESHRO, OP_ADDC, OP_SUBC, OP_EMUL, OP_EDIV, OP_AND,
    OP_NOTAND, OP_ANDNOT, OP_XOR, OP_OR, OP_NOR, OP_XNOR, OP_NOT, OP_NOTOR,
    OP_ORNOT, OP_NAND, OP_SETBIT, OP_CLRBIT, OP_NOTBIT, OP_ALTERBIT,
    OP_SCANBIT, OP_SPANBIT, OP_EXTRACT, OP_MODIFY, OP_SCANBYTE, OP_BSWAP
  } op_t;

  typedef enum logic {ST_IDLE, ST_DIV} state_t;

endpackage
`default_nettype wire

// file: core/seq_divider.sv
`timescale 1ns/100ps
`default_nettype none
`include "alu_consts.svh"
module seq_divider
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [63:0] dividend,
  input wire logic [31:0] divisor,
  output logic done,
  output logic [63:0] quot,
  output logic [31:0] rem
);
  logic [6:0] count_reg;
  logic [63:0] quot_reg;
  logic [31:0] rem_reg;
  logic [31:0] divisor_reg;
  logic done_reg;
  logic [32:0] trial;

  // one quotient bit per cycle: slow, but keeps the datapath tiny
  assign trial = {rem_reg, quot_reg[63]} - {1'b0, divisor_reg};

  // restoring division over all 64 dividend bits
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_reg <= '0;
      quot_reg <= '0;
      rem_reg <= '0;
      divisor_reg <= '0;
    end
    else if (start)
    begin
      count_reg <= `DIV_STEPS;
      quot_reg <= dividend;
      rem_reg <= '0;
      divisor_reg <= divisor;
    end
    else if (count_reg != '0)
    begin
      count_reg <= count_reg - `DIV_LAST;
      if (!trial[32])
      begin
        rem_reg <= trial[31:0];
        quot_reg <= {quot_reg[62:0], 1'b1};
      end
      else
      begin
        rem_reg <= {rem_reg[30:0], quot_reg[63]};
        quot_reg <= {quot_reg[62:0], 1'b0};
      end
    end
  end

  // done rises on the edge of the last step, when quot and rem become final
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      done_reg <= 1'b0;
    else
      done_reg <= !start && (count_reg == `DIV_LAST);
  end

  assign done = done_reg;
  assign quot = quot_reg;
  assign rem = rem_reg;
endmodule
`default_nettype wire

// file: core/integer_alu_bit_ops.sv
// How it works
// - signed add/sub/mul/div overflow raises overflow
// - divide by zero raises zero-divide fault
// - remainder follows dividend, modulo follows divisor
// - non-rotate shifts drop bits past ends
// - unsigned shifts fill with zeros
// - signed left overflow writes maximal safe shift
// - signed right shift replicates sign bit
// - dividing shift adds one for negatives that drop nonzero bits
// - rotate wraps bit 31 into bit 0
// - extended shift takes 64-bit pair, low word
// - add/sub with carry use cc bit 1
// - carry ops flag signed overflow in bit 0
// - extended multiply gives full 64-bit product
// - extended divide gives quotient and remainder
// - full set of bitwise logic operations
// - set, clear, toggle one selected bit
// - alter bit follows condition code value
// - scan finds msb one, span msb zero
// - extract right-aligns field, zero fills above
// - modify copies only masked bits
// - byte scan compares four lanes, sets cc
// - byte swap reverses four bytes
// - overflow faults or sets flag per mask
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "alu_consts.svh"
module integer_alu_bit_ops
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  import alu_pkg::*;

  logic [31:0] srcA_reg, srcB_reg, srcC_reg, resLo_reg, resHi_reg, dat_reg;
  logic [2:0] cc_reg, ccNext;
  logic ovfFlag_reg, ovfMask_reg, ovfFault_reg, zdivFault_reg, ack_reg;
  logic negQ_reg, negR_reg;
  logic [31:0] divA_reg;
  op_t op, divOp_reg;
  state_t state_reg;
  logic accept, wrAcc, cmdStart, divDone;
  logic [31:0] a, b, c, resNext, resHiNext, rdMux, absA, absB;
  logic ovfNext, zdivNext, useDiv, writeRes, writeHi;
  logic signed [63:0] prodS;
  logic [63:0] prodU, rot64, pair64, divDividend, quot;
  logic [32:0] sum33;
  logic [31:0] shliRes, quotFix, remFix, modFix, divRem;
  logic shliOvf;

  // byte-lane merge for bus writes
  function automatic logic [31:0] laneWrite(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // index of the highest set bit, all ones when none
  function automatic logic [31:0] msbIndex(input logic [31:0] v);
    logic [31:0] r;
    r = `ALL_ONES;
    for (int i = 0; i < 32; i++)
      if (v[i])
        r = 32'(i);
    return r;
  endfunction

  // low mask of n ones, saturating at a full word
  function automatic logic [31:0] lowMask(input logic [31:0] n);
    logic [31:0] r;
    r = `ALL_ONES;
    if (n < `WORD_BITS)
      r = (32'h1 << n[4:0]) - 32'h1;
    return r;
  endfunction

  function automatic logic [31:0] magnitude(input logic [31:0] v);
    return v[31] ? -v : v;
  endfunction

  assign a = srcA_reg;
  assign b = srcB_reg;
  assign c = srcC_reg;
  assign op = op_t'(dat_i[`OP_MSB:0]);

  // wishbone classic: one wait state, ack drops the cycle after it rose
  assign accept = cyc_i && stb_i && !ack_reg;
  assign wrAcc = accept && we_i;
  assign cmdStart = wrAcc && adr_i == `REG_CMD && sel_i[0] && state_reg == ST_IDLE;

  assign prodS = $signed(a) * $signed(b);
  assign prodU = {32'h0, a} * {32'h0, b};
  assign rot64 = {b, b} << a[4:0];
  assign pair64 = {c, b} >> ((a > `WORD_BITS) ? `WORD_BITS : a);
  assign absA = magnitude(a);
  assign absB = magnitude(b);

  // signed left shift: largest count that keeps the value intact
  always_comb
  begin
    logic stillOk;
    logic [4:0] best;
    stillOk = 1'b1;
    best = '0;
    for (int k = 1; k <= `MAX_SHIFT; k++)
      if (stillOk && 32'(k) <= a)
      begin
        if (($signed(b << k) >>> k) == $signed(b))
          best = 5'(k);
        else
          stillOk = 1'b0;
      end
    shliRes = b << best;
    shliOvf = (a >= `WORD_BITS) ? (b != `ZERO_WORD) : (best != a[4:0]);
  end

  // single-cycle result and fault decode of the command being written
  always_comb
  begin
    resNext = `ZERO_WORD;
    resHiNext = `ZERO_WORD;
    ccNext = cc_reg;
    ovfNext = 1'b0;
    zdivNext = 1'b0;
    useDiv = 1'b0;
    writeRes = 1'b1;
    writeHi = 1'b0;
    sum33 = '0;
    divDividend = {32'h0, b};
    unique case (op)
      OP_ADDI:
      begin
        resNext = a + b;
        ovfNext = (a[31] == b[31]) && (resNext[31] != a[31]);
      end
      OP_ADDO: resNext = a + b;
      OP_SUBI:
      begin
        resNext = b - a;
        ovfNext = (a[31] != b[31]) && (resNext[31] != b[31]);
      end
      OP_SUBO: resNext = b - a;
      OP_MULI:
      begin
        resNext = prodS[31:0];
        ovfNext = prodS[63:32] != {32{prodS[31]}};
      end
      OP_MULO: resNext = prodU[31:0];
      OP_EMUL:
      begin
        resNext = prodU[31:0];
        resHiNext = prodU[63:32];
        writeHi = 1'b1;
      end
      OP_DIVI, OP_DIVO, OP_REMI, OP_REMO, OP_MODI, OP_EDIV:
      begin
        zdivNext = a == `ZERO_WORD;
        useDiv = !zdivNext;
        writeRes = 1'b0;
        ovfNext = op == OP_DIVI && b == `INT_MIN && a == `ALL_ONES;
        if (op == OP_DIVI || op == OP_REMI || op == OP_MODI)
          divDividend = {32'h0, absB};
        else if (op == OP_EDIV)
          divDividend = {c, b};
      end
      OP_SHLO: resNext = (a >= `WORD_BITS) ? `ZERO_WORD : b << a[4:0];
      OP_SHRO: resNext = (a >= `WORD_BITS) ? `ZERO_WORD : b >> a[4:0];
      OP_SHLI:
      begin
        resNext = shliRes;
        ovfNext = shliOvf;
      end
      OP_SHRI:
        resNext = (a >= `WORD_BITS) ? {32{b[31]}} : 32'($signed(b) >>> a[4:0]);
      OP_SHRDI:
      begin
        resNext = (a >= `WORD_BITS) ? {32{b[31]}} : 32'($signed(b) >>> a[4:0]);
        if (b[31] && (b & lowMask(a)) != `ZERO_WORD)
          resNext = resNext + 32'h1;
      end
      OP_ROTATE: resNext = rot64[63:32];
      OP_ESHRO: resNext = pair64[31:0];
      OP_ADDC:
      begin
        sum33 = {1'b0, a} + {1'b0, b} + {32'h0, cc_reg[`CC_CARRY]};
        resNext = sum33[31:0];
        ccNext = {1'b0, sum33[32], (a[31] == b[31]) && (sum33[31] != a[31])};
      end
      OP_SUBC:
      begin
        sum33 = {1'b0, b} + {1'b0, ~a} + {32'h0, cc_reg[`CC_CARRY]};
        resNext = sum33[31:0];
        ccNext = {1'b0, sum33[32], (a[31] != b[31]) && (sum33[31] != b[31])};
      end
      OP_AND: resNext = b & a;
      OP_NOTAND: resNext = ~b & a;
      OP_ANDNOT: resNext = b & ~a;
      OP_XOR: resNext = b ^ a;
      OP_OR: resNext = b | a;
      OP_NOR: resNext = ~(b | a);
      OP_XNOR: resNext = ~(b ^ a);
      OP_NOT: resNext = ~a;
      OP_NOTOR: resNext = ~b | a;
      OP_ORNOT: resNext = b | ~a;
      OP_NAND: resNext = ~(b & a);
      OP_SETBIT: resNext = b | (32'h1 << a[4:0]);
      OP_CLRBIT: resNext = b & ~(32'h1 << a[4:0]);
      OP_NOTBIT: resNext = b ^ (32'h1 << a[4:0]);
      OP_ALTERBIT:
      begin
        resNext = b; // other codes leave the bit alone
        if (cc_reg == `CC_TRUE)
          resNext = b | (32'h1 << a[4:0]);
        else if (cc_reg == `CC_FALSE)
          resNext = b & ~(32'h1 << a[4:0]);
      end
      OP_SCANBIT:
      begin
        resNext = msbIndex(a);
        ccNext = (a != `ZERO_WORD) ? `CC_TRUE : `CC_FALSE;
      end
      OP_SPANBIT:
      begin
        resNext = msbIndex(~a);
        ccNext = (a != `ALL_ONES) ? `CC_TRUE : `CC_FALSE;
      end
      OP_EXTRACT: resNext = (b >> a[4:0]) & lowMask(c);
      OP_MODIFY: resNext = (b & a) | (c & ~a);
      OP_SCANBYTE:
      begin
        writeRes = 1'b0;
        ccNext = (a[7:0] == b[7:0] || a[15:8] == b[15:8] || a[23:16] == b[23:16]
                  || a[31:24] == b[31:24]) ? `CC_TRUE : `CC_FALSE;
      end
      OP_BSWAP: resNext = {a[7:0], a[15:8], a[23:16], a[31:24]};
      default: writeRes = 1'b0; // unknown codes write no result or cc; faults still clear
    endcase
  end

  seq_divider divider
  (
    .clk(clk),
    .rst_n(rst_n),
    .start(cmdStart && useDiv),
    .dividend(divDividend),
    .divisor((op == OP_DIVI || op == OP_REMI || op == OP_MODI) ? absA : a),
    .done(divDone),
    .quot(quot),
    .rem(divRem)
  );

  // sign repair of magnitude results; modulo moves toward the divisor sign
  assign quotFix = negQ_reg ? -quot[31:0] : quot[31:0];
  assign remFix = negR_reg ? -divRem : divRem;
  // a nonzero remainder of the wrong sign moves one divisor toward the divisor sign
  assign modFix = (remFix != `ZERO_WORD && remFix[31] != divA_reg[31])
                  ? remFix + divA_reg : remFix;

  // operand registers, written over the bus
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      srcA_reg <= `ZERO_WORD;
      srcB_reg <= `ZERO_WORD;
      srcC_reg <= `ZERO_WORD;
    end
    else if (wrAcc)
    begin
      if (adr_i == `REG_SRCA)
        srcA_reg <= laneWrite(srcA_reg, dat_i, sel_i);
      if (adr_i == `REG_SRCB)
        srcB_reg <= laneWrite(srcB_reg, dat_i, sel_i);
      if (adr_i == `REG_SRCC)
        srcC_reg <= laneWrite(srcC_reg, dat_i, sel_i);
    end
  end

  // divide sequencing; the divider latches its inputs, so operands may change
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      divOp_reg <= OP_ADDI;
      negQ_reg <= 1'b0;
      negR_reg <= 1'b0;
      divA_reg <= `ZERO_WORD;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
          if (cmdStart && useDiv)
          begin
            state_reg <= ST_DIV;
            divOp_reg <= op;
            negQ_reg <= op == OP_DIVI && (a[31] != b[31]);
            negR_reg <= (op == OP_REMI || op == OP_MODI) && b[31];
            divA_reg <= a; // kept whole: modulo needs the divisor at the end
          end
        ST_DIV:
          if (divDone)
            state_reg <= ST_IDLE;
      endcase
    end
  end

  // result registers, from single-cycle commands or divider completion
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      resLo_reg <= `ZERO_WORD;
      resHi_reg <= `ZERO_WORD;
    end
    else if (cmdStart && writeRes)
    begin
      resLo_reg <= resNext;
      if (writeHi)
        resHi_reg <= resHiNext;
    end
    else if (state_reg == ST_DIV && divDone)
    begin
      unique case (divOp_reg)
        OP_DIVI: resLo_reg <= quotFix;
        OP_DIVO: resLo_reg <= quot[31:0];
        OP_REMI, OP_REMO: resLo_reg <= remFix;
        OP_MODI: resLo_reg <= modFix;
        OP_EDIV:
        begin
          resLo_reg <= divRem;
          resHi_reg <= quot[31:0];
        end
        default: resLo_reg <= resLo_reg;
      endcase
    end
  end

  // faults are sticky until the next command; a new fault wins over the clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ovfFault_reg <= 1'b0;
      zdivFault_reg <= 1'b0;
    end
    else if (cmdStart)
    begin
      ovfFault_reg <= ovfNext && !ovfMask_reg;
      zdivFault_reg <= zdivNext;
    end
  end

  // arithmetic controls: software writes, hardware sets cc and overflow flag
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cc_reg <= `CC_RESET;
      ovfFlag_reg <= 1'b0;
      ovfMask_reg <= 1'b0;
    end
    else if (wrAcc && adr_i == `REG_ARITH)
    begin
      if (sel_i[0])
        cc_reg <= dat_i[`CTL_CC_MSB:0];
      if (sel_i[1])
        ovfFlag_reg <= dat_i[`CTL_OVF_FLAG];
      if (sel_i[1])
        ovfMask_reg <= dat_i[`CTL_OVF_MASK];
    end
    else if (cmdStart)
    begin
      cc_reg <= ccNext;
      if (ovfNext && ovfMask_reg)
        ovfFlag_reg <= 1'b1;
    end
  end

  // read mux; unmapped addresses read zero and ignore writes
  always_comb
  begin
    rdMux = `ZERO_WORD;
    unique case (adr_i)
      `REG_SRCA: rdMux = srcA_reg;
      `REG_SRCB: rdMux = srcB_reg;
      `REG_SRCC: rdMux = srcC_reg;
      `REG_RESLO: rdMux = resLo_reg;
      `REG_RESHI: rdMux = resHi_reg;
      `REG_STATUS:
      begin
        rdMux[`ST_BUSY] = state_reg == ST_DIV;
        rdMux[`ST_OVF_FAULT] = ovfFault_reg;
        rdMux[`ST_ZDIV_FAULT] = zdivFault_reg;
      end
      `REG_ARITH:
      begin
        rdMux[`CTL_CC_MSB:0] = cc_reg;
        rdMux[`CTL_OVF_FLAG] = ovfFlag_reg;
        rdMux[`CTL_OVF_MASK] = ovfMask_reg;
      end
      default: rdMux = `ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      dat_reg <= `ZERO_WORD;
    end
    else
    begin
      ack_reg <= accept;
      if (accept && !we_i)
        dat_reg <= rdMux;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_add_overflow: assert property (cmdStart && op == OP_ADDI && !ovfMask_reg
    && a[31] == b[31] && 32'(a + b) >> 31 != {31'h0, a[31]} |=> ovfFault_reg)
    else $error("signed add overflow not faulted");
  chk_zero_divide: assert property (cmdStart && op == OP_DIVO && a == `ZERO_WORD
    |=> zdivFault_reg && state_reg == ST_IDLE)
    else $error("zero divisor not faulted");
  chk_divide_time: assert property (cmdStart && op == OP_EDIV && a != `ZERO_WORD
    |=> (state_reg == ST_DIV) [*8] ##[57:60] state_reg == ST_IDLE)
    else $error("divide did not finish in its step count");
  chk_byte_swap: assert property (cmdStart && op == OP_BSWAP
    |=> resLo_reg[7:0] == $past(a[31:24]) && resLo_reg[31:24] == $past(a[7:0]))
    else $error("byte swap wrong");
  chk_rotate_wrap: assert property (cmdStart && op == OP_ROTATE && a == 32'h1
    |=> resLo_reg[0] == $past(b[31]))
    else $error("rotate lost bit 31");
  chk_big_shift: assert property (cmdStart && op == OP_SHRO && a >= `WORD_BITS
    |=> resLo_reg == `ZERO_WORD)
    else $error("long unsigned shift not zero");
  chk_carry_out: assert property (cmdStart && op == OP_ADDC && a == `ALL_ONES
    && b != `ZERO_WORD |=> cc_reg[`CC_CARRY])
    else $error("carry out not set");
  chk_masked_flag: assert property (cmdStart && ovfMask_reg && ovfNext
    |=> ovfFlag_reg && !ovfFault_reg)
    else $error("masked overflow did not set flag");
endmodule
`default_nettype wire

// file: test/core_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_bus_model
(
  input wire logic clk,
  output logic cycO,
  output logic stbO,
  output logic weO,
  output logic [7:0] adrO,
  output logic [3:0] selO,
  output logic [31:0] datO,
  input wire logic [31:0] datI,
  input wire logic ackI
);
  // idle bus from time zero
  initial
  begin
    cycO = 1'b0;
    stbO = 1'b0;
    weO = 1'b0;
    adrO = 8'h00;
    selO = 4'h0;
    datO = 32'h0;
  end

  // one classic cycle; waits for ack however long it takes
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    cycO <= 1'b1;
    stbO <= 1'b1;
    weO <= w;
    adrO <= a;
    selO <= s;
    datO <= d;
    do
      @(posedge clk);
    while (ackI !== 1'b1);
    q = datI;
    cycO <= 1'b0;
    stbO <= 1'b0;
    // released address and data lines flip so stale values cannot pass
    adrO <= ~a;
    datO <= ~d;
  endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "alu_consts.svh"
module tb_top;
  import alu_pkg::*;
  logic clk;
  logic rst_n;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datW;
  logic [31:0] datR;
  logic ack;
  int failCount;
  int nCompared;
  int cycles;
  logic [31:0] resLo;
  logic [31:0] resHi;
  logic [31:0] stat;
  logic [31:0] ctlWord;
  logic [31:0] rdq;

  integer_alu_bit_ops i_dut (.clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack));
  core_bus_model i_core (.clk(clk), .cycO(cyc), .stbO(stb), .weO(we), .adrO(adr),
    .selO(sel), .datO(datW), .datI(datR), .ackI(ack));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard, far above the few thousand cycles needed
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failCount++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e)
    begin
      failCount++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    i_core.xfer(1'b1, a, d, s, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    i_core.xfer(1'b0, a, 32'h0, 4'hF, q);
  endtask

  // load operands, issue, poll busy, fetch every result
  task automatic run(input op_t op, input logic [31:0] a, b, c);
    int n;
    wr(`REG_SRCA, a, 4'hF);
    wr(`REG_SRCB, b, 4'hF);
    wr(`REG_SRCC, c, 4'hF);
    wr(`REG_CMD, {26'h0, op}, 4'hF);
    n = 0;
    stat = 32'h1;
    while (stat[`ST_BUSY] !== 1'b0 && n < 100)
    begin
      rd(`REG_STATUS, stat);
      n++;
    end
    check("busy", 32'h0, stat & 32'h1);
    rd(`REG_RESLO, resLo);
    rd(`REG_RESHI, resHi);
    rd(`REG_ARITH, ctlWord);
  endtask

  task automatic ex(input op_t op, input logic [31:0] a, b, c, e);
    run(op, a, b, c);
    check("result", e, resLo);
  endtask

  task automatic st(input logic [31:0] e);
    check("fault", e, stat & 32'h6);
  endtask

  task automatic cc(input logic [31:0] e);
    check("cc", e, ctlWord & 32'h7);
  endtask

  task automatic t_reset();
    rd(`REG_STATUS, rdq);
    check("status", 32'h0, rdq);
    rd(`REG_ARITH, rdq);
    check("controls", 32'h0, rdq);
    rd(8'h40, rdq);
    check("unmapped", 32'h0, rdq);
    $display("test reset done");
  endtask

  task automatic t_arith();
    ex(OP_ADDI, 32'h7FFFFFFF, 32'h1, 32'h0, 32'h80000000);
    st(32'h2);
    ex(OP_ADDO, 32'h7FFFFFFF, 32'h1, 32'h0, 32'h80000000);
    st(32'h0);
    ex(OP_SUBO, 32'h1, 32'h0, 32'h0, 32'hFFFFFFFF);
    st(32'h0);
    ex(OP_MULO, 32'h00010000, 32'h00010000, 32'h0, 32'h0);
    st(32'h0);
    ex(OP_DIVI, 32'h2, 32'hFFFFFFF9, 32'h0, 32'hFFFFFFFD);
    st(32'h0);
    run(OP_SUBI, 32'h1, 32'h80000000, 32'h0);
    st(32'h2);
    ex(OP_MULI, 32'h00010000, 32'h00010000, 32'h0, 32'h0);
    st(32'h2);
    ex(OP_DIVI, 32'hFFFFFFFF, 32'h80000000, 32'h0, 32'h80000000);
    st(32'h2);
    ex(OP_DIVO, 32'h7, 32'h64, 32'h0, 32'hE);
    st(32'h0);
    run(OP_DIVO, 32'h0, 32'h64, 32'h0);
    st(32'h4);
    run(OP_DIVI, 32'h0, 32'h5, 32'h0);
    st(32'h4);
    // masked overflow goes to the flag, not the fault
    wr(`REG_ARITH, 32'h1000, 4'h2);
    run(OP_ADDI, 32'h7FFFFFFF, 32'h1, 32'h0);
    st(32'h0);
    check("ovf flag", 32'h100, ctlWord & 32'h100);
    wr(`REG_ARITH, 32'h0, 4'hF);
    ex(OP_REMI, 32'h2, 32'hFFFFFFF9, 32'h0, 32'hFFFFFFFF);
    ex(OP_REMO, 32'h2, 32'h7, 32'h0, 32'h1);
    ex(OP_MODI, 32'h2, 32'hFFFFFFF9, 32'h0, 32'h1);
    ex(OP_MODI, 32'hFFFFFFFE, 32'h7, 32'h0, 32'hFFFFFFFF);
    $display("test arith done");
  endtask

  task automatic t_shift();
    ex(OP_SHLO, 32'h4, 32'hF000000F, 32'h0, 32'h000000F0);
    ex(OP_SHRO, 32'h4, 32'hF000000F, 32'h0, 32'h0F000000);
    ex(OP_SHRO, 32'h20, 32'hFFFFFFFF, 32'h0, 32'h0);
    ex(OP_SHLO, 32'h28, 32'hFFFFFFFF, 32'h0, 32'h0);
    ex(OP_SHRI, 32'h4, 32'h8000000F, 32'h0, 32'hF8000000);
    ex(OP_SHRI, 32'h21, 32'h80000000, 32'h0, 32'hFFFFFFFF);
    ex(OP_SHRDI, 32'h4, 32'hFFFFFFF1, 32'h0, 32'h0);
    ex(OP_SHRDI, 32'h4, 32'hFFFFFFF0, 32'h0, 32'hFFFFFFFF);
    ex(OP_SHLI, 32'h3, 32'h20000000, 32'h0, 32'h40000000);
    st(32'h2);
    ex(OP_SHLI, 32'h1, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFE);
    st(32'h0);
    ex(OP_ROTATE, 32'h4, 32'h87654321, 32'h0, 32'h76543218);
    ex(OP_ESHRO, 32'h8, 32'h11223344, 32'hAABBCCDD, 32'hDD112233);
    ex(OP_ESHRO, 32'h20, 32'h11223344, 32'hAABBCCDD, 32'hAABBCCDD);
    $display("test shift done");
  endtask

  task automatic t_carry();
    wr(`REG_ARITH, 32'h2, 4'h1);
    ex(OP_ADDC, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0);
    cc(32'h2);
    ex(OP_ADDC, 32'h7FFFFFFF, 32'h0, 32'h0, 32'h80000000);
    cc(32'h1);
    ex(OP_SUBC, 32'h1, 32'h0, 32'h0, 32'hFFFFFFFE);
    cc(32'h0);
    wr(`REG_ARITH, 32'h2, 4'h1);
    ex(OP_SUBC, 32'h1, 32'h80000000, 32'h0, 32'h7FFFFFFF);
    cc(32'h3);
    ex(OP_EMUL, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h1);
    check("high", 32'hFFFFFFFE, resHi);
    ex(OP_EDIV, 32'h3, 32'h0, 32'h1, 32'h1);
    check("high", 32'h55555555, resHi);
    $display("test carry done");
  endtask

  // every logic op against one operand pair
  task automatic t_logic();
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] e;
    a = 32'h0F0F00FF;
    b = 32'h00FF0F0F;
    for (int i = OP_AND; i <= OP_NAND; i++)
    begin
      case (op_t'(i))
        OP_AND: e = b & a;
        OP_NOTAND: e = ~b & a;
        OP_ANDNOT: e = b & ~a;
        OP_XOR: e = b ^ a;
        OP_OR: e = b | a;
        OP_NOR: e = ~(b | a);
        OP_XNOR: e = ~(b ^ a);
        OP_NOT: e = ~a;
        OP_NOTOR: e = ~b | a;
        OP_ORNOT: e = b | ~a;
        default: e = ~(b & a);
      endcase
      ex(op_t'(i), a, b, 32'h0, e);
    end
    $display("test logic done");
  endtask

  task automatic t_bits();
    ex(OP_SETBIT, 32'h5, 32'h0, 32'h0, 32'h20);
    ex(OP_CLRBIT, 32'h1F, 32'hFFFFFFFF, 32'h0, 32'h7FFFFFFF);
    ex(OP_NOTBIT, 32'h0, 32'h3, 32'h0, 32'h2);
    wr(`REG_ARITH, 32'h2, 4'h1);
    ex(OP_ALTERBIT, 32'h4, 32'h0, 32'h0, 32'h10);
    wr(`REG_ARITH, 32'h0, 4'h1);
    ex(OP_ALTERBIT, 32'h4, 32'hFF, 32'h0, 32'hEF);
    ex(OP_SCANBIT, 32'h00010F00, 32'h0, 32'h0, 32'h10);
    cc(32'h2);
    ex(OP_SCANBIT, 32'h0, 32'h0, 32'h0, 32'hFFFFFFFF);
    cc(32'h0);
    ex(OP_SPANBIT, 32'hFFFF7FFF, 32'h0, 32'h0, 32'hF);
    ex(OP_SPANBIT, 32'hFFFFFFFF, 32'h0, 32'h0, 32'hFFFFFFFF);
    ex(OP_EXTRACT, 32'h8, 32'hABCD1234, 32'h8, 32'h12);
    ex(OP_MODIFY, 32'h0000FFFF, 32'h11112222, 32'h33334444, 32'h33332222);
    run(OP_SCANBYTE, 32'h11223344, 32'h55225566, 32'h0);
    cc(32'h2);
    run(OP_SCANBYTE, 32'h11223344, 32'h55667788, 32'h0);
    cc(32'h0);
    ex(OP_BSWAP, 32'h11223344, 32'h0, 32'h0, 32'h44332211);
    $display("test bits done");
  endtask

  // reset for 20 cycles, then the scenarios in turn
  initial
  begin
    rst_n = 1'b0;
    failCount = 0;
    nCompared = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_arith();
    t_shift();
    t_carry();
    t_logic();
    t_bits();
    finish_test();
  end
endmodule
`default_nettype wire
